// ==== src/ate_pkg.sv ====
package ate_pkg;

  // register numbers on the management register port
  localparam logic [15:0] ATE_WRITE_LOW_ADDR   = 16'h1801;
  localparam logic [15:0] ATE_WRITE_HIGH_ADDR  = 16'h1802;
  localparam logic [15:0] ATE_READ_LOW_ADDR    = 16'h1805;
  localparam logic [15:0] ATE_READ_HIGH_ADDR   = 16'h1806;

  // upper entry word field positions
  localparam int ATE_VALID_BIT       = 26;
  localparam int ATE_END_BIT         = 25;
  localparam int ATE_AGE_BIT         = 25;
  localparam int ATE_STATIC_BIT      = 24;
  localparam int ATE_FILTER_BIT      = 23;
  localparam int ATE_PRIO_EN_BIT     = 22;
  localparam int ATE_PRIO_HI         = 21;
  localparam int ATE_PRIO_LO         = 19;
  localparam int ATE_PORT_HI         = 18;
  localparam int ATE_PORT_LO         = 16;
  localparam int ATE_MAC_TAIL_HI     = 15;
  localparam int ATE_MAC_TAIL_LO     = 0;

  // writable bits of the upper write word: 26:0
  localparam logic [31:0] ATE_WRITE_HIGH_MASK  = 32'h07FF_FFFF;
  localparam logic [31:0] ATE_WRITE_LOW_RESET  = 32'h0000_0000;
  localparam logic [31:0] ATE_WRITE_HIGH_RESET = 32'h0000_0000;
  localparam logic [31:0] ATE_READ_LOW_RESET   = 32'h0000_0000;
  localparam logic [31:0] ATE_READ_HIGH_RESET  = 32'h0000_0000;

  localparam logic [2:0] ATE_PORT_RESERVED     = 3'h3;

  // entry as delivered by the table walker
  typedef struct packed {
    logic        static_entry;
    logic        filter;
    logic        prio_en;
    logic [2:0]  prio;
    logic [2:0]  port;
    logic [47:0] mac;
  } ate_entry_type;

  // management register access
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } ate_reg_req_type;

  typedef enum logic [1:0] {
    ATE_IDLE,
    ATE_SEARCH
  } ate_state_type;

endpackage : ate_pkg

// ==== src/ate_table_access.sv ====
`timescale 1ns/1ps
module ate_table_access
  import ate_pkg::*;
(
  input  wire logic            sys_clk,
  input  wire logic            nrst,
  input  wire ate_reg_req_type reg_req,
  output logic [31:0]          reg_rdata,
  output logic                 reg_ack,
  input  wire logic            fetch_first,
  input  wire logic            fetch_next,
  input  wire logic            walk_found,
  input  wire logic            walk_end,
  input  wire ate_entry_type   walk_entry,
  input  wire logic            dest_priority_precedence,
  output logic                 walk_restart,
  output logic                 walk_step,
  output logic [31:0]          entry_write_low,
  output logic [31:0]          entry_write_high,
  output logic [2:0]           write_port_mask,
  output logic                 write_port_multi,
  output logic                 write_port_reserved,
  output logic                 write_prio_active
);

  // code to port-mask decode, used by the write path only; the read path stores the raw code
  function automatic logic [2:0] ate_port_decode(input logic [2:0] code);
    case (code)
      3'h0:    ate_port_decode = 3'h1;
      3'h1:    ate_port_decode = 3'h2;
      3'h2:    ate_port_decode = 3'h4;
      3'h4:    ate_port_decode = 3'h3;
      3'h5:    ate_port_decode = 3'h5;
      3'h6:    ate_port_decode = 3'h6;
      3'h7:    ate_port_decode = 3'h7;
      default: ate_port_decode = 3'h0;
    endcase
  endfunction : ate_port_decode

  logic [31:0]   write_low;
  logic [31:0]   write_high;
  logic [31:0]   read_low;
  logic [31:0]   read_high;
  ate_state_type state;
  logic [31:0]   next_write_low;
  logic [31:0]   next_write_high;
  logic [31:0]   next_read_low;
  logic [31:0]   next_read_high;
  ate_state_type next_state;
  logic          fetch_cmd;

  assign fetch_cmd = fetch_first | fetch_next;

  // software registers
  always_comb begin
    next_write_low  = write_low;
    next_write_high = write_high;
    if (reg_req.wr && reg_req.addr == ATE_WRITE_LOW_ADDR) begin
      next_write_low = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == ATE_WRITE_HIGH_ADDR) begin
      next_write_high = reg_req.wdata & ATE_WRITE_HIGH_MASK;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      write_low  <= ATE_WRITE_LOW_RESET;
      write_high <= ATE_WRITE_HIGH_RESET;
    end else begin
      write_low  <= next_write_low;
      write_high <= next_write_high;
    end
  end

  // fetch sequencing: a new command always wins and restarts the result
  always_comb begin
    next_state     = state;
    next_read_low  = read_low;
    next_read_high = read_high;
    walk_restart   = 1'b0;
    walk_step      = 1'b0;
    if (fetch_cmd) begin
      next_read_high[ATE_VALID_BIT] = 1'b0;
      next_read_high[ATE_END_BIT]   = 1'b0;
      walk_restart = fetch_first;
      walk_step    = fetch_next & ~fetch_first;
      next_state   = ATE_SEARCH;
    end else begin
      case (state)
        ATE_IDLE: begin
          next_state = ATE_IDLE;
        end
        ATE_SEARCH: begin
          // read words take a fetch result only here; a new command clears just valid and end
          if (walk_found) begin
            next_read_low  = walk_entry.mac[31:0];
            next_read_high = '0;
            next_read_high[ATE_VALID_BIT]              = 1'b1;
            next_read_high[ATE_END_BIT]                = walk_end;
            next_read_high[ATE_STATIC_BIT]             = walk_entry.static_entry;
            next_read_high[ATE_FILTER_BIT]             = walk_entry.filter;
            next_read_high[ATE_PRIO_EN_BIT]            = walk_entry.prio_en;
            next_read_high[ATE_PRIO_HI:ATE_PRIO_LO]    = walk_entry.prio;
            next_read_high[ATE_PORT_HI:ATE_PORT_LO]    = walk_entry.port;
            next_read_high[ATE_MAC_TAIL_HI:ATE_MAC_TAIL_LO] = walk_entry.mac[47:32];
            next_state = ATE_IDLE;
          end else if (walk_end) begin
            // top reached without a hit: valid stays clear
            next_read_high[ATE_END_BIT] = 1'b1;
            next_state = ATE_IDLE;
          end
        end
        default: begin
          next_state = ATE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state     <= ATE_IDLE;
      read_low  <= ATE_READ_LOW_RESET;
      read_high <= ATE_READ_HIGH_RESET;
    end else begin
      state     <= next_state;
      read_low  <= next_read_low;
      read_high <= next_read_high;
    end
  end

  // read mux, registered; writes to read words are ignored
  logic [31:0] rdata_q;
  logic        ack_q;
  logic [31:0] next_rdata;
  logic        next_ack;

  always_comb begin
    next_ack   = reg_req.rd | reg_req.wr;
    next_rdata = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ATE_WRITE_LOW_ADDR:  next_rdata = write_low;
        ATE_WRITE_HIGH_ADDR: next_rdata = write_high;
        ATE_READ_LOW_ADDR:   next_rdata = read_low;
        ATE_READ_HIGH_ADDR:  next_rdata = read_high;
        default:             next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
      ack_q   <= 1'b0;
    end else begin
      rdata_q <= next_rdata;
      ack_q   <= next_ack;
    end
  end

  assign reg_rdata           = rdata_q;
  assign reg_ack             = ack_q;
  assign entry_write_low     = write_low;
  assign entry_write_high    = write_high;
  assign write_port_multi    = write_high[ATE_PORT_HI];
  assign write_port_mask     = ate_port_decode(write_high[ATE_PORT_HI:ATE_PORT_LO]);
  // flagged so the make-entry logic can refuse it
  assign write_port_reserved = (write_high[ATE_PORT_HI:ATE_PORT_LO] == ATE_PORT_RESERVED);
  assign write_prio_active   = write_high[ATE_PRIO_EN_BIT] & dest_priority_precedence;

endmodule : ate_table_access

// ==== verif/ate_table_access_monitor.sv ====
`timescale 1ns/1ps
module ate_table_access_monitor
  import ate_pkg::*;
(
  input wire logic            sys_clk,
  input wire logic            nrst,
  input wire ate_reg_req_type reg_req,
  input wire logic            fetch_first,
  input wire logic            fetch_next,
  input wire logic            dest_priority_precedence,
  input wire logic            walk_restart,
  input wire logic            walk_step,
  input wire logic [31:0]     entry_write_high,
  input wire logic [2:0]      write_port_mask,
  input wire logic            write_port_multi,
  input wire logic            write_port_reserved,
  input wire logic            write_prio_active
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_multi_ports: assert property (write_port_multi |-> $countones(write_port_mask) >= 2)
    else $error("multi code gives too few ports");
  chk_single_port: assert property (!write_port_multi && !write_port_reserved |-> $onehot(write_port_mask))
    else $error("single code not one port");
  chk_reserved_none: assert property (write_port_reserved |-> write_port_mask == 3'h0)
    else $error("reserved code selects a port");
  chk_reserved_code: assert property (write_port_reserved == (entry_write_high[18:16] == 3'h3))
    else $error("reserved flag wrong");
  chk_prio_gate: assert property (write_prio_active == (entry_write_high[22] && dest_priority_precedence))
    else $error("priority gating wrong");
  chk_restart_now: assert property (fetch_first |-> walk_restart)
    else $error("restart missing");
  chk_step_now: assert property (walk_step == (fetch_next && !fetch_first))
    else $error("step wrong");
  chk_tail_write: assert property (reg_req.wr && reg_req.addr == ATE_WRITE_HIGH_ADDR
    |=> entry_write_high[15:0] == $past(reg_req.wdata[15:0])) else $error("mac tail not stored");
endmodule : ate_table_access_monitor

bind ate_table_access ate_table_access_monitor ate_table_access_monitor_i (.sys_clk, .nrst, .reg_req,
  .fetch_first, .fetch_next, .dest_priority_precedence, .walk_restart, .walk_step, .entry_write_high,
  .write_port_mask, .write_port_multi, .write_port_reserved, .write_prio_active);

// ==== verif/ate_table_access_test.sv ====
`timescale 1ns/1ps
module ate_table_access_test;
  import ate_pkg::*;
  logic            sys_clk = 1'b0;
  logic            nrst = 1'b0;
  ate_reg_req_type reg_req = '0;
  logic            fetch_first = 1'b0;
  logic            fetch_next = 1'b0;
  logic            walk_found = 1'b0;
  logic            walk_end = 1'b0;
  logic            dest_priority_precedence = 1'b0;
  ate_entry_type   e = '{1'b1, 1'b0, 1'b1, 3'h5, 3'h6, 48'hA1B2_C3D4_E5F1};
  ate_entry_type   walk_entry = '{1'b1, 1'b0, 1'b1, 3'h5, 3'h6, 48'hA1B2_C3D4_E5F1};
  logic [31:0]     reg_rdata, entry_write_low, entry_write_high, d;
  logic            reg_ack, walk_restart, walk_step, write_port_multi, write_port_reserved, write_prio_active;
  logic [2:0]      write_port_mask;
  logic [2:0]      masks [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
  int              n_errors = 0;
  int              checked = 0;

  always #10 sys_clk = ~sys_clk;

  ate_table_access ate_table_access_i (
    .sys_clk                  (sys_clk),
    .nrst                     (nrst),
    .reg_req                  (reg_req),
    .reg_rdata                (reg_rdata),
    .reg_ack                  (reg_ack),
    .fetch_first              (fetch_first),
    .fetch_next               (fetch_next),
    .walk_found               (walk_found),
    .walk_end                 (walk_end),
    .walk_entry               (walk_entry),
    .dest_priority_precedence (dest_priority_precedence),
    .walk_restart             (walk_restart),
    .walk_step                (walk_step),
    .entry_write_low          (entry_write_low),
    .entry_write_high         (entry_write_high),
    .write_port_mask          (write_port_mask),
    .write_port_multi         (write_port_multi),
    .write_port_reserved      (write_port_reserved),
    .write_prio_active        (write_prio_active)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic acc(input logic wr, input logic [15:0] a, input logic [31:0] w);
    @(posedge sys_clk) reg_req <= '{wr, !wr, a, w};
    @(posedge sys_clk) reg_req <= '0;
    #1 d = reg_rdata;
    check(reg_ack, 1'b1);
  endtask : acc

  // order: fetch_first, fetch_next, walk_found, walk_end
  task automatic drive(input logic [3:0] v);
    @(posedge sys_clk) {fetch_first, fetch_next, walk_found, walk_end} <= v;
    #1 check({walk_restart, walk_step}, {v[3], v[2] & !v[3]});
    @(posedge sys_clk) {fetch_first, fetch_next, walk_found, walk_end} <= 4'h0;
  endtask : drive

  task automatic wrap_up;
    if (n_errors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    acc(0, ATE_READ_LOW_ADDR, 0);
    check(d, ATE_READ_LOW_RESET);
    acc(0, ATE_READ_HIGH_ADDR, 0);
    check(d, ATE_READ_HIGH_RESET);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk) dest_priority_precedence <= i[0];
      acc(1, ATE_WRITE_HIGH_ADDR, {5'h1F, 4'hF, i[1], 3'h5, i[2:0], 16'hBEEF});
      check(write_port_mask, masks[i]);
      check(write_port_multi, i[2]);
      check(write_port_reserved, i == 3);
      check(write_prio_active, i[1] & i[0]);
      acc(0, ATE_WRITE_HIGH_ADDR, 0);
      check(d, {5'h0, 4'hF, i[1], 3'h5, i[2:0], 16'hBEEF});
    end
    acc(1, ATE_WRITE_LOW_ADDR, 32'h1234_5678);
    check(entry_write_low, 32'h1234_5678);
    acc(0, ATE_WRITE_LOW_ADDR, 0);
    check(d, 32'h1234_5678);
    // software writes to the read words must bounce off
    acc(1, ATE_READ_LOW_ADDR, 32'hFFFF_FFFF);
    acc(0, ATE_READ_LOW_ADDR, 0);
    check(d, 32'h0);
    acc(0, 16'h1234, 0);
    check(d, 32'h0);
    drive(4'h8);
    drive(4'h2);
    acc(0, ATE_READ_HIGH_ADDR, 0);
    check(d, 32'h056E_A1B2);
    acc(0, ATE_READ_LOW_ADDR, 0);
    check(d, 32'hC3D4_E5F1);
    // a stray find outside a search must leave the words alone
    @(posedge sys_clk) walk_entry <= ~e;
    drive(4'h2);
    acc(0, ATE_READ_LOW_ADDR, 0);
    check(d, 32'hC3D4_E5F1);
    drive(4'h4);
    acc(0, ATE_READ_HIGH_ADDR, 0);
    check(d[26:25], 2'b00);
    drive(4'h1);
    acc(0, ATE_READ_HIGH_ADDR, 0);
    check(d[26:25], 2'b01);
    drive(4'h8);
    drive(4'h3);
    acc(0, ATE_READ_HIGH_ADDR, 0);
    check(d[26:25], 2'b11);
    wrap_up();
  end
endmodule : ate_table_access_test
